// *** rtl/fpo_flash_ctl.sv ***
/*
  Flash page select, block protect, information window, option load and
  trim portal, as seen from the processor register file.
  Assumes the unlock/erase sequencer reports its locked state on ctlLocked
  and the flash array answers arrAddr/arrInfo within the next cycle.
*/
// Contract
// - Shared address writes page select by default
// - Pages are 512 bytes, six-bit page match
// - Page field gives address bits 14 to 9
// - Info select maps info area at FE00h
// - Bit 6 reserved, reads zero
// - Code 5Eh while locked selects protect register
// - Any other command write deselects protect register
// - Protect resets clear, sticky once enabled
// - Pages below protect size are protected
// - Protect bit 7 enables protection
// - Option bits loaded at reset and recovery
// - Load completes before processor runs
// - Option changes act only after reload
// - Option registers hidden from software
// - User options are program bytes 0 and 1
// - Index then data write updates trim
// - Index then data read returns trim
// - Portal reaches info 20h to 3Fh only
// - Portal writes touch working copies only
// - Info FE00h-FE1Fh returns factory options
// - Info FE40h-FE57h returns device data
// - Trim index register at FF6h
// - Trim data portal at FF7h
`default_nettype none
`include "fpo_regs.svh"

module fpo_flash_ctl (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Register file access
  input  wire logic [11:0] regAddr,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [7:0]  regWrData,
  output logic [7:0]       regRdData,
  // Flash command sequencer
  input  wire logic        ctlLocked,
  input  wire logic [14:0] pgmAddr,
  output logic [5:0]       pageNum,
  output logic             infoSel,
  output logic             pgmBlocked,
  output logic             eraseBlocked,
  // Program memory fetch and flash array
  input  wire logic [15:0] pmAddr,
  input  wire logic [7:0]  arrRdData,
  output logic [14:0]      arrAddr,
  output logic             arrInfo,
  // Reset, recovery and configuration
  input  wire logic        smrReq,
  output logic             cpuRunEn,
  output logic [7:0]       optUser0,
  output logic [7:0]       optUser1,
  output logic [255:0]     trimWork
);
  import fpo_pkg::*;

  fpo_top_t s_r;
  fpo_top_t s_nxt;

  logic        ldBusy;
  logic [14:0] ldAddr;
  logic        ldInfo;
  logic [7:0]  trimRd;
  logic        wrCmd;
  logic        wrShared;
  logic        wrTrimData;
  logic        protEn;
  logic [5:0]  protSize;

  fpo_load_if ldBus ();

  //////////////////////////////////////////////////////////////////////////////
  // Submodules
  fpo_option_loader uLoader (
    .clk       (clk),
    .nrst      (nrst),
    .smrReq    (smrReq),
    .ldAddr    (ldAddr),
    .ldInfo    (ldInfo),
    .arrRdData (arrRdData),
    .busy      (ldBusy),
    .optUser0  (optUser0),
    .optUser1  (optUser1),
    .ld        (ldBus.loader)
  );

  fpo_trim_bank uBank (
    .clk      (clk),
    .nrst     (nrst),
    .ld       (ldBus.bank),
    .wrEn     (wrTrimData),
    .idx      (s_r.trimIdx),
    .wrData   (regWrData),
    .rdData   (trimRd),
    .trimWork (trimWork)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Write decode
  assign wrCmd      = regWrEn && (regAddr == `FPO_ADDR_FLASH_CMD);
  assign wrShared   = regWrEn && (regAddr == `FPO_ADDR_PAGE_PROT);
  assign wrTrimData = regWrEn && (regAddr == `FPO_ADDR_TRIM_DATA);
  assign protEn     = s_r.prot[`FPO_PROT_EN_BIT];
  assign protSize   = s_r.prot[`FPO_PAGE_MSB:0];

  //////////////////////////////////////////////////////////////////////////////
  // Next state of registers, read data and array address
  always_comb begin
    s_nxt = s_r;
    // Command writes select or release the protect register
    if (wrCmd) begin
      s_nxt.protSel = (regWrData == `FPO_CMD_PROT_ACCESS) && ctlLocked;
    end
    // Shared address: protect register only while selected
    if (wrShared) begin
      if (s_r.protSel) begin
        if (protEn) begin
          s_nxt.prot = s_r.prot | (regWrData & `FPO_WR_MASK);
        end else begin
          s_nxt.prot = regWrData & `FPO_WR_MASK;
        end
      end else begin
        s_nxt.pageSel = regWrData & `FPO_WR_MASK;
      end
    end
    // Index register keeps five bits only
    if (regWrEn && (regAddr == `FPO_ADDR_TRIM_IDX)) begin
      s_nxt.trimIdx = regWrData[`FPO_TRIM_IDX_MSB:0];
    end
    // Read data is held until the next read
    if (regRdEn) begin
      case (regAddr)
        `FPO_ADDR_TRIM_IDX:  s_nxt.rdData = {3'h0, s_r.trimIdx};
        `FPO_ADDR_TRIM_DATA: s_nxt.rdData = trimRd;
        `FPO_ADDR_PAGE_PROT: s_nxt.rdData = s_r.protSel ? s_r.prot : s_r.pageSel;
        default:             s_nxt.rdData = 8'h00;
      endcase
    end
    // Loader owns the array until done, then fetch addresses map through
    if (ldBusy) begin
      s_nxt.arrAddr = ldAddr;
      s_nxt.arrInfo = ldInfo;
    end else if (infoSel && (pmAddr >= `FPO_INFO_BASE)) begin
      s_nxt.arrAddr = {6'h00, pmAddr[8:0]};
      s_nxt.arrInfo = 1'b1;
    end else begin
      s_nxt.arrAddr = pmAddr[14:0];
      s_nxt.arrInfo = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{pageSel: `FPO_PAGE_SEL_RST, prot: `FPO_PROT_RST,
               trimIdx: `FPO_TRIM_IDX_RST, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign regRdData = s_r.rdData;
  assign pageNum   = s_r.pageSel[`FPO_PAGE_MSB:0];
  assign infoSel   = s_r.pageSel[`FPO_INFO_SEL_BIT];
  // Program limited to the selected 512-byte page, outside protected block
  assign pgmBlocked = (pgmAddr[14:9] != pageNum) ||
                      (protEn && (pgmAddr[14:9] < protSize));
  // Erase of the selected page refused when it lies in the block
  assign eraseBlocked = protEn && (pageNum < protSize);
  assign arrAddr   = s_r.arrAddr;
  assign arrInfo   = s_r.arrInfo;
  assign cpuRunEn  = !ldBusy;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Bus requests seen by the checks
  sequence s_cmdWr;
    regWrEn && (regAddr == `FPO_ADDR_FLASH_CMD);
  endsequence

  sequence s_sharedWr;
    regWrEn && (regAddr == `FPO_ADDR_PAGE_PROT);
  endsequence

  // Protect access code while the controller is locked
  sequence s_protOpen;
    s_cmdWr ##0 ((regWrData == `FPO_CMD_PROT_ACCESS) && ctlLocked);
  endsequence

  // Any other command write
  sequence s_protClose;
    s_cmdWr ##0 !((regWrData == `FPO_CMD_PROT_ACCESS) && ctlLocked);
  endsequence

  // One idle bus cycle, then a write at the shared address
  sequence s_idleShared;
    !regWrEn ##1 s_sharedWr;
  endsequence

  // Written bits land in protect; page select keeps its value
  property p_cmdSelect;
    s_protOpen ##1 s_idleShared |=> pageNum == $past(pageNum) &&
      (s_r.prot & $past(regWrData) & `FPO_WR_MASK) == ($past(regWrData) & `FPO_WR_MASK);
  endproperty
  a_cmdSelect: assert property (p_cmdSelect) else $error("protect register not reached after 5Eh");

  // Shared address falls back to page select
  property p_cmdDeselect;
    s_protClose ##1 s_idleShared |=> {2'h0, pageNum} == ($past(regWrData) & 8'h3F);
  endproperty
  a_cmdDeselect: assert property (p_cmdDeselect) else $error("command write did not release protect");

  // Page field follows the write, reserved bit stays clear
  property p_pageWrite;
    (s_sharedWr ##0 !s_r.protSel) |=> {2'h0, pageNum} == ($past(regWrData) & 8'h3F) &&
      !s_r.pageSel[`FPO_RSVD_BIT];
  endproperty
  a_pageWrite: assert property (p_pageWrite) else $error("page select not written");

  // Enabled protection never loses a bit
  property p_protSticky;
    protEn |=> protEn && (s_r.prot & $past(s_r.prot)) == $past(s_r.prot);
  endproperty
  a_protSticky: assert property (p_protSticky) else $error("protect bits cleared");

  // Reserved bit reads zero in both registers
  property p_bit6Zero;
    regRdEn && regAddr == `FPO_ADDR_PAGE_PROT |=> !regRdData[`FPO_RSVD_BIT];
  endproperty
  a_bit6Zero: assert property (p_bit6Zero) else $error("reserved bit reads one");

  // Enabling a block above the selected page blocks its erase
  property p_eraseBlock;
    (s_sharedWr ##0 (s_r.protSel && regWrData[`FPO_PROT_EN_BIT] && (regWrData[5:0] > pageNum)))
      ##1 !wrShared |-> eraseBlocked;
  endproperty
  a_eraseBlock: assert property (p_eraseBlock) else $error("protected page not blocked");

  // Programs outside the selected page are refused
  property p_pgmOutside;
    pgmAddr[14:9] != pageNum |-> pgmBlocked;
  endproperty
  a_pgmOutside: assert property (p_pgmOutside) else $error("program outside page not blocked");

  // Processor held off while recovery reloads options
  property p_loadHold;
    smrReq |=> !cpuRunEn [*8];
  endproperty
  a_loadHold: assert property (p_loadHold) else $error("processor ran during load");

  // Reload ends in bounded time
  property p_loadEnds;
    $fell(cpuRunEn) ##1 !smrReq [*8] |-> ##[20:40] cpuRunEn;
  endproperty
  a_loadEnds: assert property (p_loadEnds) else $error("option load did not finish");

  // Index keeps five bits, upper bits read back zero
  property p_trimIdxWrite;
    regWrEn && regAddr == `FPO_ADDR_TRIM_IDX |=> {3'h0, s_r.trimIdx} == ($past(regWrData) & 8'h1F);
  endproperty
  a_trimIdxWrite: assert property (p_trimIdxWrite) else $error("trim index not written");

  // Data write reaches the indexed working byte
  property p_trimPortal;
    wrTrimData && !ldBusy |=> trimRd == $past(regWrData);
  endproperty
  a_trimPortal: assert property (p_trimPortal) else $error("trim byte not written");

  // Unmapped and command reads return zero
  property p_unmappedRead;
    regRdEn && regAddr != `FPO_ADDR_TRIM_IDX && regAddr != `FPO_ADDR_TRIM_DATA &&
      regAddr != `FPO_ADDR_PAGE_PROT |=> regRdData == 8'h00;
  endproperty
  a_unmappedRead: assert property (p_unmappedRead) else $error("hidden register visible");

  // Info window maps to the info area
  property p_infoMap;
    !ldBusy && infoSel && pmAddr >= `FPO_INFO_BASE |=> arrInfo &&
      {1'b0, arrAddr} == ($past(pmAddr) & 16'h01FF);
  endproperty
  a_infoMap: assert property (p_infoMap) else $error("info window not mapped");

  // Without info select fetches go to program memory
  property p_fetchMap;
    !ldBusy && !infoSel |=> !arrInfo && {1'b0, arrAddr} == ($past(pmAddr) & 16'h7FFF);
  endproperty
  a_fetchMap: assert property (p_fetchMap) else $error("fetch not mapped to program memory");

endmodule

`default_nettype wire

// *** rtl/fpo_regs.svh ***
/*
  Register offsets, field positions, reset values and load counts of the
  flash page, protect and option-load block.
  Assumes a 12-bit register file address and an 8-bit data path.
*/
`ifndef FPO_REGS_SVH
`define FPO_REGS_SVH

// Register file addresses
`define FPO_ADDR_TRIM_IDX   12'hFF6
`define FPO_ADDR_TRIM_DATA  12'hFF7
`define FPO_ADDR_FLASH_CMD  12'hFF8
`define FPO_ADDR_PAGE_PROT  12'hFF9

// Command code that opens the protect register
`define FPO_CMD_PROT_ACCESS 8'h5E

// Field positions
`define FPO_INFO_SEL_BIT    7
`define FPO_RSVD_BIT        6
`define FPO_PROT_EN_BIT     7
`define FPO_PAGE_MSB        5
`define FPO_TRIM_IDX_MSB    4

// Writable bits of page select and block protect (bit 6 reserved)
`define FPO_WR_MASK         8'hBF

// Reset values
`define FPO_PAGE_SEL_RST    8'h00
`define FPO_PROT_RST        8'h00
`define FPO_TRIM_IDX_RST    5'h00

// Program memory window of the information area
`define FPO_INFO_BASE       16'hFE00

// Information area offset of trim byte 0
`define FPO_TRIM_INFO_BASE  9'h020

// Option load: two user option bytes then 32 trim bytes
`define FPO_OPT_BYTES       6'h02
`define FPO_LOAD_STEPS      6'h22

`endif

// *** rtl/fpo_pkg.sv ***
/*
  Types of the flash page, protect and option-load block.
  Assumes fpo_regs.svh is compiled alongside.
*/
`default_nettype none

package fpo_pkg;

  // Option loader sequence
  typedef enum logic [3:0] {
    FPO_LD_IDLE  = 4'h1,
    FPO_LD_RUN   = 4'h2,
    FPO_LD_DRAIN = 4'h4,
    FPO_LD_DONE  = 4'h8
  } fpo_ld_state_t;

  // Top-level register state
  typedef struct packed {
    logic [7:0]  pageSel;
    logic [7:0]  prot;
    logic        protSel;
    logic [4:0]  trimIdx;
    logic [7:0]  rdData;
    logic [14:0] arrAddr;
    logic        arrInfo;
  } fpo_top_t;

  // Loader state
  typedef struct packed {
    fpo_ld_state_t st;
    logic [5:0]    cnt;
    logic          v1;
    logic [5:0]    i1;
    logic [7:0]    opt0;
    logic [7:0]    opt1;
  } fpo_loader_t;

  // Working trim bytes
  typedef struct packed {
    logic [31:0][7:0] trim;
  } fpo_bank_t;

endpackage

`default_nettype wire

// *** rtl/fpo_load_if.sv ***
/*
  Carrier from the option loader to the trim bank: one write per cycle.
  Assumes both ends run on the same clock.
*/
`default_nettype none

interface fpo_load_if;
  logic       ldEn;
  logic [4:0] ldIdx;
  logic [7:0] ldData;

  modport loader (output ldEn, output ldIdx, output ldData);
  modport bank   (input ldEn, input ldIdx, input ldData);
endinterface

`default_nettype wire

// *** rtl/fpo_option_loader.sv ***
/*
  Reads the two user option bytes and the 32 factory trim bytes out of
  flash after reset and after stop-mode recovery.
  Assumes the flash array answers the registered address in the next cycle.
*/
`default_nettype none
`include "fpo_regs.svh"

module fpo_option_loader (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   nrst,
  // Restart request
  input  wire logic   smrReq,
  // Flash read request and answer
  output logic [14:0] ldAddr,
  output logic        ldInfo,
  input  wire logic [7:0] arrRdData,
  // Status and option configuration
  output logic        busy,
  output logic [7:0]  optUser0,
  output logic [7:0]  optUser1,
  // Trim initialisation writes
  fpo_load_if.loader  ld
);
  import fpo_pkg::*;

  fpo_loader_t s_r;
  fpo_loader_t s_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Sequence: issue one address per cycle, capture it one cycle later
  always_comb begin
    s_nxt = s_r;
    s_nxt.v1 = 1'b0;
    ldInfo = (s_r.cnt >= `FPO_OPT_BYTES);
    if (s_r.cnt < `FPO_OPT_BYTES) begin
      ldAddr = 15'(s_r.cnt);
    end else begin
      ldAddr = 15'(`FPO_TRIM_INFO_BASE + 9'(s_r.cnt - `FPO_OPT_BYTES));
    end
    ld.ldEn = 1'b0;
    ld.ldIdx = 5'(s_r.i1 - `FPO_OPT_BYTES);
    ld.ldData = arrRdData;
    // Capture the byte read for the previous address
    if (s_r.v1) begin
      if (s_r.i1 == 6'h00) begin
        s_nxt.opt0 = arrRdData;
      end else if (s_r.i1 == 6'h01) begin
        s_nxt.opt1 = arrRdData;
      end else begin
        ld.ldEn = 1'b1;
      end
    end
    case (s_r.st)
      FPO_LD_IDLE: begin
        s_nxt.cnt = 6'h00;
        s_nxt.st = FPO_LD_RUN;
      end
      FPO_LD_RUN: begin
        s_nxt.v1 = 1'b1;
        s_nxt.i1 = s_r.cnt;
        if (s_r.cnt == `FPO_LOAD_STEPS - 6'h01) begin
          s_nxt.st = FPO_LD_DRAIN;
        end else begin
          s_nxt.cnt = s_r.cnt + 6'h01;
        end
      end
      FPO_LD_DRAIN: s_nxt.st = FPO_LD_DONE;
      FPO_LD_DONE:  s_nxt.st = FPO_LD_DONE;
      default:      s_nxt.st = FPO_LD_IDLE;
    endcase
    // Stop-mode recovery reloads everything
    if (smrReq) begin
      s_nxt.st = FPO_LD_IDLE;
      s_nxt.v1 = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register; option bytes change only through a load
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{st: FPO_LD_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign busy = (s_r.st != FPO_LD_DONE);
  assign optUser0 = s_r.opt0;
  assign optUser1 = s_r.opt1;

endmodule

`default_nettype wire

// *** rtl/fpo_trim_bank.sv ***
/*
  The 32 volatile working trim bytes, filled by the loader and reached
  by software through the index and data portal.
  Assumes the loader and the portal never write in the same cycle.
*/
`default_nettype none
`include "fpo_regs.svh"

module fpo_trim_bank (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   nrst,
  // Load writes
  fpo_load_if.bank    ld,
  // Software portal
  input  wire logic       wrEn,
  input  wire logic [4:0] idx,
  input  wire logic [7:0] wrData,
  output logic [7:0]  rdData,
  // Working values to the analog blocks
  output logic [255:0] trimWork
);
  import fpo_pkg::*;

  fpo_bank_t s_r;
  fpo_bank_t s_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Load wins over a portal write; flash is never written from here
  always_comb begin
    s_nxt = s_r;
    if (ld.ldEn) begin
      s_nxt.trim[ld.ldIdx] = ld.ldData;
    end else if (wrEn) begin
      s_nxt.trim[idx] = wrData;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Portal read and flat output
  assign rdData = s_r.trim[idx];
  assign trimWork = s_r.trim;

endmodule

`default_nettype wire

// *** test/fpo_flash_model.sv ***
/*
  Behavioural flash array for the flash page, protect and option-load block.
  Assumes the controller registers arrAddr/arrInfo and samples data in that cycle.
*/
`default_nettype none

module fpo_flash_model (
  // Array address and target
  input  wire logic [14:0] arrAddr,
  input  wire logic        arrInfo,
  // Swaps in a reprogrammed user option byte 0
  input  wire logic        altOpt,
  // Read data
  output logic [7:0]       arrRdData
);
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////
  // Read-only pattern, so portal writes never reach stored bytes
  always_comb begin
    if (arrInfo) begin
      arrRdData = arrAddr[7:0] ^ 8'hC3;
    end else if (arrAddr == 15'h0000 && altOpt) begin
      arrRdData = 8'h3C;
    end else begin
      arrRdData = arrAddr[7:0] ^ 8'h5A;
    end
  end
endmodule

`default_nettype wire

// *** test/fpo_flash_ctl_test.sv ***
/*
  Self-checking bench of fpo_flash_ctl.
  Assumes fpo_flash_model stands for the flash array.
*/
`default_nettype none
`include "fpo_regs.svh"

module fpo_flash_ctl_test;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [7:0]  wd;
    logic [7:0]  rd;
    logic [15:0] pm;
    logic        ai;
    logic [14:0] aa;
    logic [14:0] pg;
    logic        pb;
  } fpo_row_t;

  logic         clk       = 1'b0;
  logic         nrst      = 1'b0;
  logic [11:0]  regAddr   = 12'h000;
  logic         regWrEn   = 1'b0;
  logic         regRdEn   = 1'b0;
  logic [7:0]   regWrData = 8'h00;
  logic         ctlLocked = 1'b0;
  logic [14:0]  pgmAddr   = 15'h0000;
  logic [15:0]  pmAddr    = 16'h0000;
  logic         smrReq    = 1'b0;
  logic         altOpt    = 1'b0;
  logic [7:0]   regRdData;
  logic [5:0]   pageNum;
  logic         infoSel;
  logic         pgmBlocked;
  logic         eraseBlocked;
  logic [7:0]   arrRdData;
  logic [14:0]  arrAddr;
  logic         arrInfo;
  logic         cpuRunEn;
  logic [7:0]   optUser0;
  logic [7:0]   optUser1;
  logic [255:0] trimWork;
  int           numErrors = 0;
  int           totalChecks = 0;
  int           cycles = 0;

  // Page select write, readback and fetch mapping
  fpo_row_t rows [6] = '{
    '{8'h80, 8'h80, 16'hFE45, 1'b1, 15'h0045, 15'h0000, 1'b0},
    '{8'h81, 8'h81, 16'hFE1F, 1'b1, 15'h001F, 15'h03FF, 1'b0},
    '{8'h05, 8'h05, 16'hFE45, 1'b0, 15'h7E45, 15'h0A00, 1'b0},
    '{8'h3F, 8'h3F, 16'hFFFF, 1'b0, 15'h7FFF, 15'h7E00, 1'b0},
    '{8'hFF, 8'hBF, 16'hFFFF, 1'b1, 15'h01FF, 15'h7C00, 1'b1},
    '{8'h02, 8'h02, 16'h0400, 1'b0, 15'h0400, 15'h0600, 1'b1}};

  fpo_flash_ctl i_fpo_flash_ctl (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData), .ctlLocked(ctlLocked),
    .pgmAddr(pgmAddr), .pageNum(pageNum), .infoSel(infoSel), .pgmBlocked(pgmBlocked),
    .eraseBlocked(eraseBlocked), .pmAddr(pmAddr), .arrRdData(arrRdData), .arrAddr(arrAddr),
    .arrInfo(arrInfo), .smrReq(smrReq), .cpuRunEn(cpuRunEn), .optUser0(optUser0),
    .optUser1(optUser1), .trimWork(trimWork));

  fpo_flash_model i_fpo_flash_model (.arrAddr(arrAddr), .arrInfo(arrInfo), .altOpt(altOpt),
    .arrRdData(arrRdData));

  ////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #20 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      numErrors++;
      closeOut();
    end
  end

  ////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk);
    #1 regWrEn = 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 regAddr = a;
    regRdEn = 1'b1;
    @(posedge clk);
    #1 regRdEn = 1'b0;
    chk(nm, exp, regRdData);
  endtask

  task automatic waitRun();
    int n;
    n = 0;
    while (cpuRunEn !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1 n++;
    end
    chk("cpuRunEn", 1, cpuRunEn);
  endtask

  task automatic loadChk(input logic [7:0] o0);
    chk("optUser0", o0, optUser0);
    chk("optUser1", 8'h5B, optUser1);
    for (int i = 0; i < 32; i++) begin
      chk("trimWork", 8'(i + 32) ^ 8'hC3, trimWork[8*i +: 8]);
    end
  endtask

  task automatic closeOut();
    if (numErrors == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    chk("cpuRunEn", 0, cpuRunEn);
    #1 nrst = 1'b1;
    waitRun();
    loadChk(8'h5A);
    foreach (rows[i]) begin
      wr(`FPO_ADDR_PAGE_PROT, rows[i].wd);
      pmAddr = rows[i].pm;
      pgmAddr = rows[i].pg;
      rdc("pageSel", `FPO_ADDR_PAGE_PROT, rows[i].rd);
      chk("pageNum", rows[i].wd[5:0], pageNum);
      chk("infoSel", rows[i].wd[7], infoSel);
      chk("arrInfo", rows[i].ai, arrInfo);
      chk("arrAddr", rows[i].aa, arrAddr);
      chk("pgmBlocked", rows[i].pb, pgmBlocked);
    end
    // Protect access code while unlocked leaves page select in place
    wr(`FPO_ADDR_FLASH_CMD, `FPO_CMD_PROT_ACCESS);
    wr(`FPO_ADDR_PAGE_PROT, 8'h03);
    chk("pageNum", 3, pageNum);
    ctlLocked = 1'b1;
    wr(`FPO_ADDR_FLASH_CMD, `FPO_CMD_PROT_ACCESS);
    rdc("prot", `FPO_ADDR_PAGE_PROT, 8'h00);
    wr(`FPO_ADDR_PAGE_PROT, 8'hC3);
    rdc("prot", `FPO_ADDR_PAGE_PROT, 8'h83);
    chk("pageNum", 3, pageNum);
    pgmAddr = 15'h0600;
    chk("eraseBlocked", 0, eraseBlocked);
    wr(`FPO_ADDR_PAGE_PROT, 8'h00);
    rdc("prot", `FPO_ADDR_PAGE_PROT, 8'h83);
    wr(`FPO_ADDR_FLASH_CMD, 8'h00);
    wr(`FPO_ADDR_PAGE_PROT, 8'h02);
    rdc("pageSel", `FPO_ADDR_PAGE_PROT, 8'h02);
    pgmAddr = 15'h0400;
    #1 chk("eraseBlocked", 1, eraseBlocked);
    chk("pgmBlocked", 1, pgmBlocked);
    // Trim portal at both index ends
    wr(`FPO_ADDR_TRIM_IDX, 8'hFF);
    rdc("trimIdx", `FPO_ADDR_TRIM_IDX, 8'h1F);
    wr(`FPO_ADDR_TRIM_DATA, 8'hA5);
    rdc("trimData", `FPO_ADDR_TRIM_DATA, 8'hA5);
    chk("trim31", 8'hA5, trimWork[255:248]);
    chk("trim0", 8'hE3, trimWork[7:0]);
    wr(`FPO_ADDR_TRIM_IDX, 8'h00);
    wr(`FPO_ADDR_TRIM_DATA, 8'h3C);
    rdc("trimData", `FPO_ADDR_TRIM_DATA, 8'h3C);
    rdc("unmapped", 12'hFFA, 8'h00);
    rdc("cmdRead", `FPO_ADDR_FLASH_CMD, 8'h00);
    // Reprogrammed option acts only after recovery reload
    altOpt = 1'b1;
    repeat (3) @(posedge clk);
    chk("optUser0", 8'h5A, optUser0);
    #1 smrReq = 1'b1;
    @(posedge clk);
    #1 smrReq = 1'b0;
    chk("cpuRunEn", 0, cpuRunEn);
    waitRun();
    loadChk(8'h3C);
    // Reset in mid-run clears sticky protection
    wr(`FPO_ADDR_FLASH_CMD, `FPO_CMD_PROT_ACCESS);
    wr(`FPO_ADDR_PAGE_PROT, 8'h85);
    rdc("prot", `FPO_ADDR_PAGE_PROT, 8'h87);
    chk("eraseBlocked", 1, eraseBlocked);
    nrst = 1'b0;
    #1 chk("regRdData", 0, regRdData);
    chk("cpuRunEn", 0, cpuRunEn);
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    waitRun();
    wr(`FPO_ADDR_FLASH_CMD, `FPO_CMD_PROT_ACCESS);
    rdc("prot", `FPO_ADDR_PAGE_PROT, 8'h00);
    chk("eraseBlocked", 0, eraseBlocked);
    closeOut();
  end
endmodule

`default_nettype wire
